// [logic/tlic_top.sv]
// Purpose: two-level interrupt controller with APB registers
// Assumes: core answers pcLoad by vectoring, pulses returnFromIrq on return
// Notes:   sources 7:4 are peripheral, 3:0 are core sources
//
// Behaviour
// - high vector 0008h, low vector 0018h
// - high request preempts a low handler
// - each source has flag, enable, priority
// - priority mode only while mode bit set
// - priority mode: bit 7 enables high sources
// - priority mode: bit 6 enables low sources
// - flag, enable, level enable set: vector
// - reset gives compatibility mode, priority ignored
// - compat: bit 6 peripherals, bit 7 all
// - compat: every interrupt goes to 0008h
// - accepting clears the admitting global enable
// - no low vector during high handler
// - vector pushes return, loads vector address
// - return pops and re-sets exited level enable
// - pin events vector within three-four cycles
// - flags set regardless of any enable
// - clearing one enable stops only that source
// - priority mode: bit 6 gates every low source, peripheral or core
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "tlic_params.svh"

module tlic_top (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // apb slave
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // interrupt source pins
  input  wire logic [7:0]           srcEvent,
  // core side
  input  wire logic                 returnFromIrq,
  output tlic_pkg::tlic_core_t      coreOut
);
  import tlic_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic anyPend(input logic [7:0] f, input logic [7:0] e,
                                   input logic [7:0] m);
    anyPend = |(f & e & m);
  endfunction

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == `TLIC_OFF_CTRL) || (a == `TLIC_OFF_RSTCTL) ||
               (a == `TLIC_OFF_FLAG) || (a == `TLIC_OFF_ENABLE) ||
               (a == `TLIC_OFF_PRIO) || (a == `TLIC_OFF_STATUS);
  endfunction

  // ****************************************
  // pin synchroniser
  // ****************************************
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic [7:0] next_sync1;
  logic [7:0] next_sync2;
  logic [7:0] next_sync3;

  always_comb begin
    next_sync1 = srcEvent;
    next_sync2 = sync1;
    next_sync3 = sync2;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      sync3 <= next_sync3;
    end
  end

  // ****************************************
  // interrupt state
  // ****************************************
  logic [7:0] flag;
  logic [7:0] enable;
  logic [7:0] prio;
  logic       gHigh;
  logic       gLow;
  logic       pmode;
  logic       inHigh;
  logic       inLow;
  logic [7:0] next_flag;
  logic [7:0] next_enable;
  logic [7:0] next_prio;
  logic       next_gHigh;
  logic       next_gLow;
  logic       next_pmode;
  logic       next_inHigh;
  logic       next_inLow;
  tlic_core_t next_coreOut;

  logic [7:0]  edgeHit;
  logic        apbDone;
  logic        wrByte;
  logic        hiReq;
  logic        loReq;
  logic        cReq;
  logic        accept;
  tlic_level_t acceptLvl;

  always_comb begin
    // edge taken between the second and third flop, never the first
    edgeHit = sync2 & ~sync3;
    apbDone = psel & penable & pready;
    wrByte  = apbDone & pwrite & pstrb[0];

    // hardware set wins over a software clear in the same cycle
    next_flag = ((wrByte && paddr == `TLIC_OFF_FLAG) ? pwdata[7:0] : flag)
                | edgeHit;
    next_enable = (wrByte && paddr == `TLIC_OFF_ENABLE) ? pwdata[7:0] : enable;
    next_prio   = (wrByte && paddr == `TLIC_OFF_PRIO) ? pwdata[7:0] : prio;
    next_pmode  = (wrByte && paddr == `TLIC_OFF_RSTCTL) ?
                  pwdata[`TLIC_BIT_PMODE] : pmode;
    next_gHigh  = (wrByte && paddr == `TLIC_OFF_CTRL) ? pwdata[`TLIC_BIT_GHIGH] : gHigh;
    next_gLow   = (wrByte && paddr == `TLIC_OFF_CTRL) ? pwdata[`TLIC_BIT_GLOW] : gLow;

    // requests; per-source enable masks each source alone
    hiReq = pmode && gHigh && !inHigh && anyPend(flag, enable, prio);
    loReq = pmode && gLow && !inHigh &&
            anyPend(flag, enable, ~prio);
    cReq  = !pmode && gHigh && !inHigh &&
            (anyPend(flag, enable, ~`TLIC_PERIPH_MASK) ||
             (gLow && anyPend(flag, enable, `TLIC_PERIPH_MASK)));
    // one-cycle gap after each vector lets the core settle
    accept    = !coreOut.pcLoad && (hiReq || loReq || cReq);
    acceptLvl = (hiReq || cReq) ? TLIC_LVL_HIGH : TLIC_LVL_LOW;

    next_inHigh  = inHigh;
    next_inLow   = inLow;
    next_coreOut = '0;

    // return re-arms the level being exited
    if (returnFromIrq) begin
      next_coreOut.popReturn = 1'b1;
      if (inHigh) begin
        next_inHigh = 1'b0;
        next_gHigh  = 1'b1;
      end else if (inLow) begin
        next_inLow = 1'b0;
        next_gLow  = 1'b1;
      end
    end

    // accepting clears the admitting enable; this wins over a software set
    if (accept) begin
      next_coreOut.pcLoad     = 1'b1;
      next_coreOut.pushReturn = 1'b1;
      if (acceptLvl == TLIC_LVL_HIGH) begin
        next_coreOut.vectorAddr = `TLIC_VEC_HIGH;
        next_gHigh  = 1'b0;
        next_inHigh = 1'b1;
      end else begin
        next_coreOut.vectorAddr = `TLIC_VEC_LOW;
        next_gLow  = 1'b0;
        next_inLow = 1'b1;
      end
    end
  end

  // pin edge to pcLoad is two sync edges, flag edge, vector edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag    <= `TLIC_RST_BYTE;
      enable  <= `TLIC_RST_BYTE;
      prio    <= `TLIC_RST_BYTE;
      gHigh   <= 1'b0;
      gLow    <= 1'b0;
      pmode   <= 1'b0;
      inHigh  <= 1'b0;
      inLow   <= 1'b0;
      coreOut <= '0;
    end else begin
      flag    <= next_flag;
      enable  <= next_enable;
      prio    <= next_prio;
      gHigh   <= next_gHigh;
      gLow    <= next_gLow;
      pmode   <= next_pmode;
      inHigh  <= next_inHigh;
      inLow   <= next_inLow;
      coreOut <= next_coreOut;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  // one wait state so read data and error come straight from flops
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;

  always_comb begin
    next_pready  = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h00000000;
    if (psel && penable && !pready) begin
      next_pslverr = !isMapped(paddr);
      case (paddr)
        `TLIC_OFF_CTRL: begin
          next_prdata[`TLIC_BIT_GHIGH] = gHigh;
          next_prdata[`TLIC_BIT_GLOW]  = gLow;
        end
        `TLIC_OFF_RSTCTL: begin
          next_prdata[`TLIC_BIT_PMODE] = pmode;
        end
        `TLIC_OFF_FLAG: begin
          next_prdata[7:0] = flag;
        end
        `TLIC_OFF_ENABLE: begin
          next_prdata[7:0] = enable;
        end
        `TLIC_OFF_PRIO: begin
          next_prdata[7:0] = prio;
        end
        `TLIC_OFF_STATUS: begin
          next_prdata[`TLIC_BIT_INHIGH] = inHigh;
          next_prdata[`TLIC_BIT_INLOW]  = inLow;
        end
        default: begin
          next_prdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_hiWin;
    hiReq && !coreOut.pcLoad;
  endsequence

  sequence s_hiTaken;
    coreOut.pcLoad && coreOut.vectorAddr == `TLIC_VEC_HIGH && !gHigh && inHigh;
  endsequence

  sequence s_loTaken;
    coreOut.pcLoad && coreOut.vectorAddr == `TLIC_VEC_LOW && !gLow && inLow;
  endsequence

  property p_vecAddr;
    coreOut.pcLoad |-> (coreOut.vectorAddr == `TLIC_VEC_HIGH) ||
                       (coreOut.vectorAddr == `TLIC_VEC_LOW);
  endproperty
  a_vecAddr: assert property (p_vecAddr) else $error("bad vector address");

  property p_hiAccept;
    s_hiWin |=> s_hiTaken;
  endproperty
  a_hiAccept: assert property (p_hiAccept) else $error("high request not vectored");

  property p_loAccept;
    (loReq && !hiReq && !coreOut.pcLoad) |=> s_loTaken;
  endproperty
  a_loAccept: assert property (p_loAccept) else $error("low request not vectored");

  property p_preempt;
    (inLow && hiReq && !coreOut.pcLoad) |=> s_hiTaken;
  endproperty
  a_preempt: assert property (p_preempt) else $error("high did not preempt low");

  property p_compatVec;
    (coreOut.pcLoad && !$past(pmode)) |-> coreOut.vectorAddr == `TLIC_VEC_HIGH;
  endproperty
  a_compatVec: assert property (p_compatVec) else $error("compat vector not 0008h");

  property p_noLowInHigh;
    inHigh |=> !(coreOut.pcLoad && coreOut.vectorAddr == `TLIC_VEC_LOW);
  endproperty
  a_noLowInHigh: assert property (p_noLowInHigh) else $error("low vector in high");

  property p_push;
    coreOut.pcLoad |-> coreOut.pushReturn && !$past(coreOut.pcLoad);
  endproperty
  a_push: assert property (p_push) else $error("vector without push");

  property p_flagSet;
    (|edgeHit) |=> (flag & $past(edgeHit)) == $past(edgeHit);
  endproperty
  a_flagSet: assert property (p_flagSet) else $error("flag not set by event");

  property p_return;
    (returnFromIrq && inHigh && !accept) |=> gHigh && !inHigh && coreOut.popReturn;
  endproperty
  a_return: assert property (p_return) else $error("return did not re-arm");

  property p_gateHigh;
    (pmode && !gHigh) |=> !(coreOut.pcLoad && coreOut.vectorAddr == `TLIC_VEC_HIGH);
  endproperty
  a_gateHigh: assert property (p_gateHigh) else $error("high vector while gated");

  property p_gateLow;
    (pmode && !gLow) |=> !(coreOut.pcLoad && coreOut.vectorAddr == `TLIC_VEC_LOW);
  endproperty
  a_gateLow: assert property (p_gateLow) else $error("low vector while gated");

  property p_compatOff;
    (!pmode && !gHigh) |=> !coreOut.pcLoad;
  endproperty
  a_compatOff: assert property (p_compatOff) else $error("vector with global off");

  property p_popRet;
    returnFromIrq |=> coreOut.popReturn;
  endproperty
  a_popRet: assert property (p_popRet) else $error("return without pop");

  property p_oneShot;
    coreOut.pcLoad |=> !coreOut.pcLoad;
  endproperty
  a_oneShot: assert property (p_oneShot) else $error("vector pulse too long");

endmodule

// [logic/tlic_params.svh]
// Purpose: constants of the two-level interrupt controller
// Assumes: APB byte addresses, 8 interrupt sources
// Notes:   definitions only
`ifndef TLIC_PARAMS_SVH
`define TLIC_PARAMS_SVH

// ****************************************
// sources and vectors
// ****************************************
`define TLIC_NSRC         8
`define TLIC_PERIPH_MASK  8'hf0
`define TLIC_VEC_HIGH     16'h0008
`define TLIC_VEC_LOW      16'h0018

// ****************************************
// register offsets
// ****************************************
`define TLIC_OFF_CTRL     12'h000
`define TLIC_OFF_RSTCTL   12'h004
`define TLIC_OFF_FLAG     12'h008
`define TLIC_OFF_ENABLE   12'h00c
`define TLIC_OFF_PRIO     12'h010
`define TLIC_OFF_STATUS   12'h014

// ****************************************
// field positions and reset values
// ****************************************
`define TLIC_BIT_GHIGH    7
`define TLIC_BIT_GLOW     6
`define TLIC_BIT_PMODE    7
`define TLIC_BIT_INHIGH   0
`define TLIC_BIT_INLOW    1
`define TLIC_RST_BYTE     8'h00

`endif

// [logic/tlic_pkg.sv]
// Purpose: types of the two-level interrupt controller
// Assumes: tlic_params.svh supplies the numbers
// Notes:   carrier structs for the core side
package tlic_pkg;

  // ****************************************
  // core-facing carrier
  // ****************************************
  typedef struct packed {
    logic        pcLoad;
    logic        pushReturn;
    logic        popReturn;
    logic [15:0] vectorAddr;
  } tlic_core_t;

  // ****************************************
  // which level was admitted
  // ****************************************
  typedef enum logic {
    TLIC_LVL_LOW,
    TLIC_LVL_HIGH
  } tlic_level_t;

endpackage

// [test/tlic_core_model.sv]
// Purpose: core-side partner of the interrupt controller
// Assumes: one clock, controller pulses on coreOut
// Notes:   keeps the return-address stack depth
`timescale 1ns/1ps
module tlic_core_model (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  // controller side
  input  tlic_pkg::tlic_core_t coreOut,
  output logic                 returnFromIrq,
  // bench side
  input  wire logic            retCmd,
  output logic [3:0]           depth,
  output logic                 pairErr
);
  import tlic_pkg::*;
  // ********
  // return and stack
  // ********
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      returnFromIrq <= 1'b0;
      depth         <= 4'h0;
      pairErr       <= 1'b0;
    end else begin
      // the bench asks for a return only after clearing the served flags
      returnFromIrq <= retCmd;
      depth <= depth + {3'h0, coreOut.pushReturn} - {3'h0, coreOut.popReturn};
      if (coreOut.pcLoad !== coreOut.pushReturn) begin
        pairErr <= 1'b1;
      end
    end
  end
endmodule

// [test/tlic_top_tb_top.sv]
// Purpose: self-checking bench of the interrupt controller
// Assumes: one wait state on apb, vector 3-4 cycles after a pin
// Notes:   random setups plus directed nesting cases
`timescale 1ns/1ps
`include "tlic_params.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errCount++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tlic_top_tb_top;
  import tlic_pkg::*;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        retCmd, returnFromIrq, pairErr, pm;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  pstrb, depth;
  logic [7:0]  srcEvent, en, pr, ct, s;
  logic [15:0] ev;
  logic        er;
  int          errCount, checked;
  tlic_core_t  coreOut;

  tlic_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .srcEvent(srcEvent),
    .returnFromIrq(returnFromIrq), .coreOut(coreOut));
  tlic_core_model core (.clk_sys(clk_sys), .rst_n(rst_n), .coreOut(coreOut),
    .returnFromIrq(returnFromIrq), .retCmd(retCmd), .depth(depth), .pairErr(pairErr));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ********
  // tasks
  // ********
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, errCount);
    if (errCount == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one single-word access at a time, never a two-step move
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      errCount++;
      give_verdict();
    end
    rd = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, rdv, er);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e, input string n);
    apb(1'b0, a, 8'h00, rdv, er);
    `CHK(n, {24'h0, e}, rdv)
    `CHK(n, 1'b0, er)
  endtask

  // pins held three cycles; a missing or wrong vector shows as got
  task automatic fire(input logic [7:0] pins, input logic [15:0] v);
    int          lat;
    logic [15:0] got;
    lat = 0;
    got = 16'h0;
    srcEvent <= pins;
    for (int k = 1; k <= 8; k++) begin
      @(posedge clk_sys);
      if (k == 3) srcEvent <= 8'h00;
      if (coreOut.pcLoad === 1'b1 && lat == 0) begin
        lat = k - 1;
        got = coreOut.vectorAddr;
      end
    end
    `CHK("vector", v, got)
    if (pins != 8'h00 && v != 16'h0) `CHK("latency", 1'b1, lat >= 3 && lat <= 4)
  endtask

  task automatic ret();
    retCmd <= 1'b1;
    @(posedge clk_sys);
    retCmd <= 1'b0;
    @(posedge clk_sys);
  endtask

  function automatic logic [15:0] expVec(input logic m, input logic [7:0] c, e, p, f);
    logic [7:0] act;
    act = f & e;
    if (m) begin
      if (c[7] && |(act & p)) return `TLIC_VEC_HIGH;
      if (c[6] && |(act & ~p)) return `TLIC_VEC_LOW;
      return 16'h0;
    end
    if (!c[6]) act = act & ~`TLIC_PERIPH_MASK;
    return (c[7] && |act) ? `TLIC_VEC_HIGH : 16'h0;
  endfunction

  // ********
  // sequence
  // ********
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'hf; srcEvent = 8'h00; retCmd = 1'b0;
    errCount = 0; checked = 0;
    void'($urandom(8343));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a <= 20; a += 4) rdc(12'(a), 8'h00, "reset value");
    apb(1'b0, 12'h018, 8'h00, rdv, er);
    `CHK("unmapped", 1'b1, er)
    wr(`TLIC_OFF_ENABLE, 8'hff);
    // a write with the low strobe off must leave the register alone
    pstrb <= 4'he;
    wr(`TLIC_OFF_ENABLE, 8'h00);
    pstrb <= 4'hf;
    rdc(`TLIC_OFF_ENABLE, 8'hff, "strobe off");
    wr(`TLIC_OFF_CTRL, 8'h80);
    fire(8'h10, 16'h0);
    wr(`TLIC_OFF_FLAG, 8'h00);
    fire(8'h01, `TLIC_VEC_HIGH);
    wr(`TLIC_OFF_FLAG, 8'h00);
    ret();
    fire(8'h00, 16'h0);
    rdc(`TLIC_OFF_CTRL, 8'h80, "ctrl compat");
    wr(`TLIC_OFF_RSTCTL, 8'h80);
    wr(`TLIC_OFF_PRIO, 8'h01);
    wr(`TLIC_OFF_CTRL, 8'hc0);
    fire(8'h02, `TLIC_VEC_LOW);
    fire(8'h01, `TLIC_VEC_HIGH);
    `CHK("depth", 4'h2, depth)
    wr(`TLIC_OFF_CTRL, 8'h40);
    fire(8'h04, 16'h0);
    wr(`TLIC_OFF_FLAG, 8'h00);
    ret();
    ret();
    fire(8'h00, 16'h0);
    rdc(`TLIC_OFF_CTRL, 8'hc0, "ctrl nested");
    fire(8'h03, `TLIC_VEC_HIGH);
    wr(`TLIC_OFF_FLAG, 8'h02);
    ret();
    fire(8'h00, `TLIC_VEC_LOW);
    wr(`TLIC_OFF_FLAG, 8'h00);
    ret();
    fire(8'h00, 16'h0);
    for (int i = 0; i < 16; i++) begin
      pm = 1'($urandom);
      en = 8'($urandom);
      pr = 8'($urandom);
      ct = {2'($urandom), 6'h00};
      s = 8'h01 << ($urandom % 8);
      ev = expVec(pm, ct, en, pr, s);
      wr(`TLIC_OFF_CTRL, 8'h00);
      wr(`TLIC_OFF_FLAG, 8'h00);
      wr(`TLIC_OFF_RSTCTL, {pm, 7'h00});
      wr(`TLIC_OFF_ENABLE, en);
      wr(`TLIC_OFF_PRIO, pr);
      wr(`TLIC_OFF_CTRL, ct);
      fire(s, ev);
      rdc(`TLIC_OFF_FLAG, s, "flag");
      if (ev != 16'h0) begin
        rdc(`TLIC_OFF_CTRL, ct & ((ev == `TLIC_VEC_HIGH) ? 8'h7f : 8'hbf), "ctrl");
        rdc(`TLIC_OFF_STATUS, (ev == `TLIC_VEC_HIGH) ? 8'h01 : 8'h02, "status");
        wr(`TLIC_OFF_FLAG, 8'h00);
        ret();
        fire(8'h00, 16'h0);
        rdc(`TLIC_OFF_CTRL, ct, "ctrl back");
      end
    end
    `CHK("stack", 5'h00, {pairErr, depth})
    give_verdict();
  end
endmodule
